// ==== core/drad_decode.sv ====
`timescale 1ns/1ps
`default_nettype none
module drad_decode
  import drad_pkg::*;
(
  // payload of a readback select command
  input wire logic [15:0] payload,
  // decoded selection
  output logic [3:0] kind,
  output logic [4:0] chan,
  output logic [1:0] abs_idx
);
  logic [5:0] ch6;
  logic [7:0] gsel;
  logic [5:0] chofs;
  logic [7:0] gofs;
  // ==========================================================
  // bits 6..0 are never looked at
  assign ch6 = payload[CHAN_HI:CHAN_LO];
  assign gsel = payload[GSEL_HI:GSEL_LO];
  assign chofs = ch6 - CHAN_BASE;
  assign gofs = gsel - GSEL_ABS0;
  always_comb begin
    kind = KIND_NONE;
    chan = 5'h00;
    abs_idx = 2'h0;
    if (payload[GLOBAL_BIT]) begin
      // global selects, 4 and 10 reserved
      if (gsel == GSEL_CTRL) kind = KIND_CTRL;
      else if (gsel == GSEL_OFFSET_DAC_REG_0) kind = KIND_OFFSET_DAC_REG_0;
      else if (gsel == GSEL_OFFSET_DAC_REG_1) kind = KIND_OFFSET_DAC_REG_1;
      else if (gsel >= GSEL_ABS0 && gsel <= GSEL_ABS3) begin
        kind = KIND_ABS;
        abs_idx = gofs[1:0];
      end
    end else if (ch6 >= CHAN_BASE && ch6 <= CHAN_LAST) begin
      chan = chofs[4:0];
      case (payload[TYPE_HI:TYPE_LO])
        TYPE_IN_A: kind = KIND_IN_A;
        TYPE_IN_B: kind = KIND_IN_B;
        TYPE_OFFS: kind = KIND_OFFS;
        TYPE_GAIN: kind = KIND_GAIN;
        default: kind = KIND_NONE;
      endcase
    end
  end
endmodule // drad_decode
`default_nettype wire

// ==== core/drad_pkg.sv ====
package drad_pkg;
  // ==========================================================
  // serial frame layout
  localparam int FRAME_BITS = 24;
  localparam int MODE_HI = 23;
  localparam int MODE_LO = 22;
  localparam int SFC_HI = 21;
  localparam int SFC_LO = 16;
  localparam int TYPE_HI = 15;
  localparam int TYPE_LO = 13;
  localparam int CHAN_HI = 12;
  localparam int CHAN_LO = 7;
  localparam int GSEL_HI = 14;
  localparam int GSEL_LO = 7;
  localparam int GLOBAL_BIT = 15;
  localparam int DATA_BITS = 16;
  // ==========================================================
  // codes
  localparam logic [1:0] MODE_SPECIAL = 2'h0;
  localparam logic [5:0] SFC_NOP = 6'h00;
  localparam logic [5:0] SFC_READSEL = 6'h05;
  localparam logic [15:0] DATA_NOP = 16'h0000;
  localparam logic [2:0] TYPE_IN_A = 3'h0;
  localparam logic [2:0] TYPE_IN_B = 3'h1;
  localparam logic [2:0] TYPE_OFFS = 3'h2;
  localparam logic [2:0] TYPE_GAIN = 3'h3;
  localparam logic [5:0] CHAN_BASE = 6'h08;
  localparam logic [5:0] CHAN_LAST = 6'h27;
  localparam logic [7:0] GSEL_CTRL = 8'h01;
  localparam logic [7:0] GSEL_OFFSET_DAC_REG_0 = 8'h02;
  localparam logic [7:0] GSEL_OFFSET_DAC_REG_1 = 8'h03;
  localparam logic [7:0] GSEL_ABS0 = 8'h06;
  localparam logic [7:0] GSEL_ABS3 = 8'h09;
  // register kind on the readback mux
  localparam logic [3:0] KIND_NONE = 4'h0;
  localparam logic [3:0] KIND_IN_A = 4'h1;
  localparam logic [3:0] KIND_IN_B = 4'h2;
  localparam logic [3:0] KIND_OFFS = 4'h3;
  localparam logic [3:0] KIND_GAIN = 4'h4;
  localparam logic [3:0] KIND_CTRL = 4'h5;
  localparam logic [3:0] KIND_OFFSET_DAC_REG_0 = 4'h6;
  localparam logic [3:0] KIND_OFFSET_DAC_REG_1 = 4'h7;
  localparam logic [3:0] KIND_ABS = 4'h8;
endpackage

// ==== core/drad_readback.sv ====
`timescale 1ns/1ps
`default_nettype none
module drad_readback
  import drad_pkg::*;
#(
  parameter int NCH = 32
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // serial pins
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  // register contents to read back
  input wire logic [NCH*16-1:0] in_a_data,
  input wire logic [NCH*16-1:0] in_b_data,
  input wire logic [NCH*16-1:0] offs_data,
  input wire logic [NCH*16-1:0] gain_data,
  input wire logic [15:0] ctrl_data,
  input wire logic [15:0] offset_dac_reg_0_data,
  input wire logic [15:0] offset_dac_reg_1_data,
  input wire logic [31:0] abs_data,
  // decoded frame
  output logic frame_done,
  output logic [23:0] frame_word,
  output logic read_armed
);
  typedef enum logic [2:0] {
    DRAD_IDLE = 3'b001,
    DRAD_SHIFT = 3'b010,
    DRAD_END = 3'b100
  } drad_state_e;
  // ==========================================================
  // pin synchronisers
  logic [2:0] s1, s2;
  logic sclk_q, next_sclk_q;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s1 <= 3'h7;
      s2 <= 3'h7;
      sclk_q <= 1'b1;
    end else begin
      s1 <= {sclk, sync_n, sdi};
      s2 <= s1;
      sclk_q <= next_sclk_q;
    end
  end
  logic sclk_s, sync_s, sdi_s, sclk_fall, sclk_rise;
  assign sclk_s = s2[2];
  assign sync_s = s2[1];
  assign sdi_s = s2[0];
  assign sclk_fall = sclk_q & ~sclk_s;
  assign sclk_rise = ~sclk_q & sclk_s;
  always_comb next_sclk_q = sclk_s;
  // ==========================================================
  // selection decode
  logic [3:0] kind;
  logic [4:0] chan;
  logic [1:0] abs_idx;
  drad_decode u_dec (
    .payload(frame_word[15:0]),
    .kind(kind),
    .chan(chan),
    .abs_idx(abs_idx)
  );
  function automatic logic [15:0] pick(input logic [NCH*16-1:0] v, input logic [4:0] c);
    pick = v[c*16 +: 16];
  endfunction
  logic [15:0] sel_val;
  always_comb begin
    case (kind)
      KIND_IN_A: sel_val = pick(in_a_data, chan);
      KIND_IN_B: sel_val = pick(in_b_data, chan);
      KIND_OFFS: sel_val = pick(offs_data, chan);
      KIND_GAIN: sel_val = pick(gain_data, chan);
      KIND_CTRL: sel_val = ctrl_data;
      KIND_OFFSET_DAC_REG_0: sel_val = offset_dac_reg_0_data;
      KIND_OFFSET_DAC_REG_1: sel_val = offset_dac_reg_1_data;
      KIND_ABS: sel_val = {8'h00, abs_data[abs_idx*8 +: 8]};
      default: sel_val = 16'h0000;
    endcase
  end
  // ==========================================================
  // frame engine
  drad_state_e state, next_state;
  logic [23:0] shreg, next_shreg;
  logic [4:0] cnt, next_cnt;
  logic [15:0] txreg, next_txreg;
  logic armed, next_armed, oe, next_oe, done, next_done;
  logic [23:0] next_word;
  logic load_tx, next_load_tx;
  logic is_special, is_readsel, is_nop;
  assign is_special = shreg[MODE_HI:MODE_LO] == MODE_SPECIAL;
  assign is_readsel = is_special && shreg[SFC_HI:SFC_LO] == SFC_READSEL;
  assign is_nop = is_special && shreg[SFC_HI:SFC_LO] == SFC_NOP
    && shreg[15:0] == DATA_NOP;
  always_comb begin
    next_state = state;
    next_shreg = shreg;
    next_cnt = cnt;
    next_txreg = txreg;
    next_armed = armed;
    next_oe = oe;
    next_done = 1'b0;
    next_word = frame_word;
    case (state)
      DRAD_IDLE: begin
        if (!sync_s) begin
          next_state = DRAD_SHIFT;
          next_cnt = 5'h00;
          // a pending read drives its data during this frame
          next_oe = armed;
        end
      end
      DRAD_SHIFT: begin
        if (sync_s) begin
          next_state = DRAD_IDLE;
          next_oe = 1'b0;
        end else begin
          if (sclk_fall && cnt != 5'(FRAME_BITS)) begin
            next_shreg = {shreg[22:0], sdi_s};
            next_cnt = cnt + 5'h01;
          end
          if (sclk_rise && oe && cnt != 5'h00) begin
            next_txreg = {txreg[14:0], 1'b0};
          end
          if (cnt == 5'(FRAME_BITS)) next_state = DRAD_END;
        end
      end
      DRAD_END: begin
        if (sync_s) begin
          next_state = DRAD_IDLE;
          next_oe = 1'b0;
          next_done = 1'b1;
          next_word = shreg;
          if (is_readsel) next_armed = 1'b1;
          else if (is_nop) next_armed = 1'b0;
          else next_armed = 1'b0;
        end
      end
      default: next_state = DRAD_IDLE;
    endcase
    // latch the selected value once the select frame word is stored
    if (load_tx) next_txreg = sel_val;
  end
  always_comb next_load_tx = done && armed;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state <= DRAD_IDLE;
      shreg <= 24'h000000;
      cnt <= 5'h00;
      txreg <= 16'h0000;
      armed <= 1'b0;
      oe <= 1'b0;
      done <= 1'b0;
      frame_word <= 24'h000000;
      load_tx <= 1'b0;
    end else begin
      state <= next_state;
      shreg <= next_shreg;
      cnt <= next_cnt;
      txreg <= next_txreg;
      armed <= next_armed;
      oe <= next_oe;
      done <= next_done;
      frame_word <= next_word;
      load_tx <= next_load_tx;
    end
  end
  assign sdo = oe & txreg[15];
  assign sdo_oe = oe;
  assign frame_done = done;
  assign read_armed = armed;
  // ==========================================================
  // checks
  sequence seq_sel_frame;
    done && is_readsel;
  endsequence
  AST_ARM_ON_SELECT: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(done) && frame_word[23:16] == {MODE_SPECIAL, SFC_READSEL} |-> armed)
    else $error("readback select did not arm");
  AST_NOP_DISARMS: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(done) && frame_word == 24'h000000 |-> !armed)
    else $error("nop frame left read armed");
  AST_OE_ONLY_ARMED: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(oe) |-> $past(armed) && $past(state) == DRAD_IDLE)
    else $error("sdo driven without pending read");
  AST_OE_OFF_IDLE: assert property (@(posedge mclk) disable iff (!rstn)
    state == DRAD_IDLE && $past(state) == DRAD_IDLE |-> !sdo_oe)
    else $error("sdo driven outside a frame");
  AST_LOAD_AFTER: assert property (@(posedge mclk) disable iff (!rstn)
    seq_sel_frame |=> ##1 txreg == $past(sel_val))
    else $error("selected value not loaded");
  AST_MSB_SHIFT: assert property (@(posedge mclk) disable iff (!rstn)
    $changed(txreg) && !$past(load_tx) |-> txreg == {$past(txreg[14:0]), 1'b0})
    else $error("shift not msb first");
  AST_CHAN_MAP: assert property (@(posedge mclk) disable iff (!rstn)
    !frame_word[GLOBAL_BIT] && kind != KIND_NONE
    |-> chan == 5'(frame_word[CHAN_HI:CHAN_LO] - CHAN_BASE))
    else $error("channel mapping wrong");
  AST_RESERVED: assert property (@(posedge mclk) disable iff (!rstn)
    frame_word[GLOBAL_BIT] && (frame_word[GSEL_HI:GSEL_LO] == 8'h04
    || frame_word[GSEL_HI:GSEL_LO] == 8'h0a) |-> kind == KIND_NONE)
    else $error("reserved select decoded");
  AST_LOW_IGNORED: assert property (@(posedge mclk) disable iff (!rstn)
    $stable(frame_word[15:7]) && $changed(frame_word[6:0]) |-> $stable(kind))
    else $error("low payload bits affected select");
endmodule // drad_readback
`default_nettype wire

// ==== dv/drad_host.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========
// serial host model: sclk idles high, frames of up to 24 bits (nbits) msb first
module drad_host (
  // clock
  input wire logic mclk,
  // serial pins
  output logic sclk,
  output logic sync_n,
  output logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe
);
  initial begin
    sclk = 1'b1;
    sync_n = 1'b1;
    sdi = 1'b0;
  end
  // one frame of nbits; rx gets the sdo line, oe_rx the device's drive enable
  task automatic xfer(input logic [23:0] w, input int nbits, output logic [23:0] rx,
    output logic [23:0] oe_rx);
    int i;
    @(negedge mclk) sync_n <= 1'b0;
    repeat (8) @(negedge mclk);
    for (i = 23; i >= 24 - nbits; i--) begin
      sdi <= w[i];
      repeat (4) @(negedge mclk);
      sclk <= 1'b0;
      // an undriven line reads as the inverse of the pin
      rx[i] = sdo_oe ? sdo : ~sdo;
      oe_rx[i] = sdo_oe;
      repeat (4) @(negedge mclk);
      sclk <= 1'b1;
    end
    repeat (4) @(negedge mclk);
    sync_n <= 1'b1;
    // released line shows the inverse of its last value
    sdi <= ~sdi;
  endtask
endmodule // drad_host
`default_nettype wire

// ==== dv/test_drad_readback.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========
// readback bench
module test_drad_readback
  import drad_pkg::*;
;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic sclk, sync_n, sdi, sdo, sdo_oe, frame_done, read_armed;
  logic [511:0] in_a_data = '0, in_b_data = '0, offs_data = '0, gain_data = '0;
  logic [15:0] ctrl_data = '0, offset_dac_reg_0_data = '0, offset_dac_reg_1_data = '0;
  logic [31:0] abs_data = '0;
  logic [23:0] frame_word, rx, oe_rx;
  logic last_armed = 1'b0;
  logic [31:0] seed = 32'hb544;
  int num_errors = 0;
  int total_checks = 0;

  initial forever #20 mclk = ~mclk;

  drad_readback #(.NCH(32)) dut_u (.mclk(mclk), .rstn(rstn), .sclk(sclk),
    .sync_n(sync_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .in_a_data(in_a_data),
    .in_b_data(in_b_data), .offs_data(offs_data), .gain_data(gain_data),
    .ctrl_data(ctrl_data), .offset_dac_reg_0_data(offset_dac_reg_0_data), .offset_dac_reg_1_data(offset_dac_reg_1_data),
    .abs_data(abs_data), .frame_done(frame_done), .frame_word(frame_word),
    .read_armed(read_armed));
  drad_host host_u (.mclk(mclk), .sclk(sclk), .sync_n(sync_n), .sdi(sdi), .sdo(sdo),
    .sdo_oe(sdo_oe));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // expected register value for a readback select payload
  function automatic logic [15:0] model(logic [15:0] p);
    int c;
    int g;
    c = int'(p[12:7]) - 8;
    g = int'(p[14:7]);
    if (!p[15]) begin
      if (c < 0 || c > 31) return 16'h0000;
      case (p[14:13])
        2'h0: return in_a_data[c*16+:16];
        2'h1: return in_b_data[c*16+:16];
        2'h2: return offs_data[c*16+:16];
        default: return gain_data[c*16+:16];
      endcase
    end
    case (g)
      1: return ctrl_data;
      2: return offset_dac_reg_0_data;
      3: return offset_dac_reg_1_data;
      6, 7, 8, 9: return {8'h00, abs_data[(g-6)*8+:8]};
      default: return 16'h0000;
    endcase
  endfunction

  task automatic check(string what, logic [23:0] exp, logic [23:0] got);
    total_checks++;
    if (exp !== got) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic frame(logic [23:0] w, logic armed);
    int n;
    host_u.xfer(w, 24, rx, oe_rx);
    n = 0;
    while (frame_done !== 1'b1 && n < 20) begin
      @(negedge mclk);
      n++;
    end
    check("frame_done", 24'h1, {23'h0, frame_done});
    check("frame_word", w, frame_word);
    check("read_armed", {23'h0, armed}, {23'h0, read_armed});
    check("sdo_oe", last_armed ? 24'hffffff : 24'h000000, oe_rx);
    check("sdo_oe idle", 24'h0, {23'h0, sdo_oe});
    last_armed = armed;
    repeat (8) @(negedge mclk);
  endtask

  // a frame cut short is refused: no done, select state kept
  task automatic cut(logic [23:0] w, logic [23:0] keep);
    logic seen;
    seen = 1'b0;
    host_u.xfer(w, 12, rx, oe_rx);
    repeat (20) begin
      @(negedge mclk);
      if (frame_done !== 1'b0) seen = 1'b1;
    end
    check("cut frame_done", 24'h0, {23'h0, seen});
    check("cut frame_word", keep, frame_word);
    check("cut read_armed", {23'h0, last_armed}, {23'h0, read_armed});
  endtask

  task automatic readback(logic [15:0] p);
    frame({MODE_SPECIAL, SFC_READSEL, p}, 1'b1);
    frame(24'h000000, 1'b0);
    check("sdo", {model(p), 8'h00}, rx);
  endtask

  task automatic finish_test();
    if (num_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    #(30000 * 40);
    num_errors++;
    finish_test();
  end

  initial begin
    int i;
    logic [15:0] p;
    repeat (5) @(negedge mclk);
    rstn = 1'b1;
    for (i = 0; i < 16; i++) begin
      in_a_data[i*32+:32] = rnd();
      in_b_data[i*32+:32] = rnd();
      offs_data[i*32+:32] = rnd();
      gain_data[i*32+:32] = rnd();
    end
    {ctrl_data, offset_dac_reg_0_data} = rnd();
    offset_dac_reg_1_data = 16'(rnd());
    abs_data = rnd();
    repeat (4) @(negedge mclk);
    check("reset frame_word", 24'h0, frame_word);
    check("reset flags", 24'h0, {20'h0, sdo, sdo_oe, frame_done, read_armed});
    // per-channel registers, both channel ends, random and invalid codes
    for (i = 0; i < 20; i++) begin
      p = 16'(rnd());
      p[15:13] = {1'b0, i[1:0]};
      if (i < 8) p[12:7] = i[2] ? CHAN_LAST : CHAN_BASE;
      readback(p);
    end
    // every global code including the reserved ones
    for (i = 0; i < 12; i++) begin
      p = 16'(rnd());
      p[15:7] = {1'b1, i[7:0]};
      readback(p);
    end
    frame({MODE_SPECIAL, SFC_READSEL, 16'h8080}, 1'b1);
    // only the ignored low bits differ from the select before
    readback(16'h80ff);
    frame({MODE_SPECIAL, SFC_READSEL, 16'h8080}, 1'b1);
    cut({MODE_SPECIAL, SFC_NOP, DATA_NOP}, {MODE_SPECIAL, SFC_READSEL, 16'h8080});
    frame({MODE_SPECIAL, 6'h02, 16'h1234}, 1'b0);
    finish_test();
  end
endmodule // test_drad_readback
`default_nettype wire
